// [selftest_defines.svh]
// Offsets, field positions, test codes and timing constants of the sequencer
`ifndef SELFTEST_DEFINES_SVH
`define SELFTEST_DEFINES_SVH

// Register offsets
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define CTRL_HOST_BIT  0

// Test numbers, held as the octal values 1 to 17 packed into four bits
`define TEST_CORE      4'hF
`define TEST_ARITH     4'hE
`define TEST_HOSTCHIP  4'hD
`define TEST_FIFO      4'hC
`define TEST_FMT       4'hA
`define TEST_LAST      4'h1
`define SEL_SEEK       4'h1
`define SEL_TUNE       4'h2
`define SEL_SUITE      4'h0

// Lamp patterns
`define LAMPS_ALL      4'hF
`define LAMPS_OFF      4'h0

// Eighth-word check: end-of-word strobes before the flag may rise
`define FMT_WORDS      4'h8

// Brief lamp flash
`define FLASH_MS       50
`define CLK_KHZ        40000
`define FLASH_CYCLES   (`FLASH_MS * `CLK_KHZ)

`endif

// [selftest_pkg.sv]
// Types shared by the self-test sequencer and its surroundings
package selftest_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FLASH   = 3'b001,
    ST_RUN     = 3'b010,
    ST_WAIT    = 3'b011,
    ST_SHOW    = 3'b100,
    ST_HALT    = 3'b101,
    ST_HANG    = 3'b110,
    ST_LOCK    = 3'b111
  } seq_state_t;

  typedef struct packed {
    logic       normal_position;
    logic [3:0] test_select;
    logic       start;
  } panel_in_t;

  typedef struct packed {
    logic [3:0] result;
    logic       fail;
  } lamps_t;

  typedef struct packed {
    logic       go;
    logic [3:0] num;
  } test_req_t;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic [3:0] section;
    logic       end_of_word_strobe;
    logic       eighth_word_flag;
  } test_rsp_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage

// [selftest_seq.sv]
// Self-test sequencer: panel switches, test dispatch, lamps and hang logic
//
// Functional notes
// - Normal position, start press runs whole suite once, ignoring selector.
// - Normal run flashes all lamps; error shows number and fail lamp.
// - Normal with start held loops suite to first error, restarts.
// - Normal held start flashes lamps each pass, hides errors until release.
// - Service, selector above 2: loop test until error, then halt.
// - Single test loop flashes its number; error shows section (tests 16 and 15 show their number), fail lamp.
// - Service selector 2: start tuning procedure, flash 2.
// - Service selector 1: command random seeks, flash 1.
// - Service selector 0: loop suite, flash numbers, halt on error.
// - Service held start loops and restarts; only test 17 still hangs.
// - Host commands ignored unless switch is in normal position.
// - Test 17 runs first; fault locks until power or spindle reset.
// - Test 17 failure shows 17 in both switch positions.
// - Test 16 failure hangs showing 16 unless start held; press releases.
// - Test 15 checks host interface chip; fail shows 15, hangs.
// - Test 14 checks FIFOs; reports sections, exits to firmware.
// - Test 13 loops FIFO data through host interface chip.
// - Test 12 first loops a pattern through formatter and compares.
// - Test 12 then checks overrun on empty FIFO.
// - Test 12 eighth-word flag only after sixteenth byte.
// - Normal: self-test runs at power-on, host command or start press.
// - Result lamps give failing test in octal; dark on pass.
`timescale 1ns/1ps
`include "selftest_defines.svh"

module selftest_seq
  import selftest_pkg::*;
#(
  parameter int FLASH_CYCLES = `FLASH_CYCLES
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Spindle run switch restart
  input  wire logic      spindle_restart,
  // Panel switches and lamps
  input  wire panel_in_t panel,
  output lamps_t         lamps,
  // Test engine
  output test_req_t      test_req,
  input  wire test_rsp_t test_rsp,
  // Drive and host side
  output logic           tune_go,
  output logic           seek_go,
  output logic           host_enable,
  output logic           firmware_run,
  // Register port
  input  wire bus_req_t  bus,
  output logic [31:0]    rdata
);

  typedef struct packed {
    seq_state_t  st;
    logic [3:0]  cur;
    logic [3:0]  err_num;
    logic        err_pend;
    logic        suite;
    logic        service;
    logic [23:0] timer;
    logic        start_prev;
    logic [3:0]  words;
    logic        fmt_err;
    lamps_t      lamps;
    test_req_t   req;
    logic        tune;
    logic        seek;
    logic        host_en;
    logic        fw;
    logic [31:0] rdata;
  } regs_t;

  regs_t q;
  regs_t d;

  localparam logic [23:0] FLASH_LOAD = 24'(FLASH_CYCLES - 1);

  // **************************************************************
  // Helpers
  // **************************************************************
  function automatic logic hangs_on_fail(input logic [3:0] num);
    return (num == `TEST_ARITH) || (num == `TEST_HOSTCHIP);
  endfunction

  function automatic logic [31:0] status_word(input regs_t r);
    return {19'h0_0000, r.lamps.fail, r.lamps.result, r.cur,
            r.st, r.service};
  endfunction

  logic press;
  logic held;
  logic host_cmd;
  logic fmt_early;

  assign press    = panel.start & ~q.start_prev;
  assign held     = panel.start;
  assign host_cmd = bus.wr && (bus.addr == `REG_CTRL) &&
                    bus.wdata[`CTRL_HOST_BIT] && panel.normal_position &&
                    q.host_en;
  assign fmt_early = (q.cur == `TEST_FMT) && test_rsp.eighth_word_flag &&
                     (q.words < `FMT_WORDS);

  // **************************************************************
  // Next state
  // **************************************************************
  always_comb begin
    d            = q;
    d.start_prev = panel.start;
    d.req.go     = 1'b0;
    d.tune       = 1'b0;
    d.seek       = 1'b0;
    d.rdata      = 32'h0000_0000;
    if (bus.rd && bus.addr == `REG_STATUS) begin
      d.rdata = status_word(q);
    end
    if (q.timer != 24'h00_0000) begin
      d.timer = q.timer - 24'h00_0001;
    end
    // count end-of-word strobes, catch an early flag
    if (q.st == ST_WAIT && q.cur == `TEST_FMT) begin
      if (test_rsp.end_of_word_strobe && q.words != 4'hF) begin
        d.words = q.words + 4'h1;
      end
      if (fmt_early) begin
        d.fmt_err = 1'b1;
      end
    end

    unique case (q.st)
      ST_IDLE: begin
        // suite in normal position, selector ignored
        if (panel.normal_position && (press || host_cmd)) begin
          d.st       = ST_FLASH;
          d.suite    = 1'b1;
          d.service  = 1'b0;
          d.err_pend = 1'b0;
          d.lamps    = '{result: `LAMPS_ALL, fail: 1'b1};
          d.timer    = FLASH_LOAD;
        end else if (!panel.normal_position && press) begin
          d.service = 1'b1;
          d.lamps   = '{result: `LAMPS_OFF, fail: 1'b0};
          if (panel.test_select == `SEL_SUITE) begin
            d.suite = 1'b1;
            d.cur   = `TEST_CORE;
            d.st    = ST_RUN;
          end else if (panel.test_select == `SEL_SEEK) begin
            d.seek         = 1'b1;
            d.lamps.result = `SEL_SEEK;
            d.timer        = FLASH_LOAD;
            d.st           = ST_SHOW;
            d.suite        = 1'b0;
            d.cur          = `SEL_SEEK;
          end else if (panel.test_select == `SEL_TUNE) begin
            d.tune         = 1'b1;
            d.lamps.result = `SEL_TUNE;
            d.timer        = FLASH_LOAD;
            d.st           = ST_SHOW;
            d.suite        = 1'b0;
            d.cur          = `SEL_TUNE;
          end else begin
            d.suite = 1'b0;
            d.cur   = panel.test_select;
            d.st    = ST_RUN;
          end
        end
      end
      ST_FLASH: begin
        // all lamps lit briefly, then the suite
        if (q.timer == 24'h00_0000) begin
          d.lamps = '{result: `LAMPS_OFF, fail: 1'b0};
          d.cur   = `TEST_CORE;
          d.st    = ST_RUN;
        end
      end
      ST_RUN: begin
        d.req     = '{go: 1'b1, num: q.cur};
        d.words   = 4'h0;
        d.fmt_err = 1'b0;
        d.st      = ST_WAIT;
      end
      ST_WAIT: begin
        if (test_rsp.done && (test_rsp.fail || q.fmt_err || fmt_early)) begin
          if (q.cur == `TEST_CORE) begin
            d.lamps = '{result: `TEST_CORE, fail: 1'b1};
            d.st    = ST_LOCK;
          end else if (held) begin
            // held start restarts, error kept hidden
            d.err_pend = ~q.service;
            d.err_num  = q.cur;
            d.cur      = q.suite ? `TEST_CORE : q.cur;
            d.st       = q.service ? ST_RUN : ST_FLASH;
            if (!q.service) begin
              d.lamps = '{result: `LAMPS_ALL, fail: 1'b1};
              d.timer = FLASH_LOAD;
            end
          end else if (!q.service) begin
            d.lamps = '{result: q.cur, fail: 1'b1};
            d.st    = hangs_on_fail(q.cur) ? ST_HANG : ST_IDLE;
          end else begin
            // service halt, section or test shown
            d.lamps.result = (q.suite || hangs_on_fail(q.cur)) ?
                             q.cur : test_rsp.section;
            d.lamps.fail   = 1'b1;
            d.st           = hangs_on_fail(q.cur) ? ST_HANG : ST_HALT;
          end
        end else if (test_rsp.done) begin
          if (q.service) begin
            d.lamps.result = q.cur;
            d.timer        = FLASH_LOAD;
            d.st           = ST_SHOW;
          end else if (q.cur != `TEST_LAST) begin
            d.cur = q.cur - 4'h1;
            d.st  = ST_RUN;
          end else if (held) begin
            d.lamps = '{result: `LAMPS_ALL, fail: 1'b1};
            d.timer = FLASH_LOAD;
            d.st    = ST_FLASH;
          end else begin
            // dark on pass, held-start error shown on release
            d.lamps = q.err_pend ? lamps_t'{result: q.err_num, fail: 1'b1}
                                 : lamps_t'{result: `LAMPS_OFF, fail: 1'b0};
            d.st    = ST_IDLE;
          end
        end
      end
      ST_SHOW: begin
        if (q.timer == 24'h00_0000) begin
          d.lamps.result = `LAMPS_OFF;
          if (!q.suite && (q.cur == `SEL_SEEK || q.cur == `SEL_TUNE)) begin
            d.st = ST_IDLE;
          end else if (q.suite && q.cur != `TEST_LAST) begin
            d.cur = q.cur - 4'h1;
            d.st  = ST_RUN;
          end else begin
            d.cur = q.suite ? `TEST_CORE : q.cur;
            d.st  = ST_RUN;
          end
        end
      end
      ST_HALT, ST_HANG: begin
        // start press releases the halt or hang
        if (press) begin
          d.lamps = '{result: `LAMPS_OFF, fail: 1'b0};
          d.cur   = q.suite ? `TEST_CORE : q.cur;
          d.st    = q.service ? ST_RUN : ST_IDLE;
        end
      end
      ST_LOCK: d.st = ST_LOCK;
    endcase

    // spindle run switch restarts the self-test
    if (spindle_restart) begin
      d.st       = ST_FLASH;
      d.suite    = 1'b1;
      d.service  = 1'b0;
      d.err_pend = 1'b0;
      d.lamps    = '{result: `LAMPS_ALL, fail: 1'b1};
      d.timer    = FLASH_LOAD;
    end
    // host bus served only in normal position while idle
    d.host_en = panel.normal_position && (d.st == ST_IDLE);
    d.fw      = panel.normal_position && (d.st == ST_IDLE);
  end

  // **************************************************************
  // State register
  // **************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      q         <= '0;
      q.st      <= ST_FLASH;
      q.suite   <= 1'b1;
      q.lamps   <= '{result: `LAMPS_ALL, fail: 1'b1};
      q.timer   <= FLASH_LOAD;
    end else begin
      q <= d;
    end
  end

  assign lamps        = q.lamps;
  assign test_req     = q.req;
  assign tune_go      = q.tune;
  assign seek_go      = q.seek;
  assign host_enable  = q.host_en;
  assign firmware_run = q.fw;
  assign rdata        = q.rdata;

  // **************************************************************
  // Assertions
  // **************************************************************
  sequence s_core_fail;
    q.st == ST_WAIT && test_rsp.done && test_rsp.fail &&
    q.cur == `TEST_CORE;
  endsequence

  sequence s_locked;
    q.st == ST_LOCK && q.lamps.result == `TEST_CORE && q.lamps.fail;
  endsequence

  a_core_lock: assert property (@(posedge clk) disable iff (rst)
    s_core_fail |=> s_locked ##1 (s_locked or $past(spindle_restart)))
    else $error("test 17 failure did not lock");

  a_lock_holds: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_LOCK && !spindle_restart) |=> s_locked)
    else $error("lock left without spindle restart");

  a_normal_start: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_IDLE && panel.normal_position && press && !spindle_restart)
    |=> q.st == ST_FLASH && q.lamps.result == `LAMPS_ALL && q.suite)
    else $error("normal start did not flash");

  a_low_fail_exit: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_WAIT && test_rsp.done && test_rsp.fail && !held &&
     !q.service && q.cur <= `TEST_FIFO && !spindle_restart)
    |=> q.st == ST_IDLE && q.lamps.fail && q.lamps.result == $past(q.cur)
        ##1 firmware_run || !panel.normal_position)
    else $error("low test failure did not exit to firmware");

  a_held_hides: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_WAIT && test_rsp.done && test_rsp.fail && held &&
     !q.service && q.cur != `TEST_CORE && !spindle_restart)
    |=> q.st == ST_FLASH && q.lamps.result == `LAMPS_ALL)
    else $error("held start showed an error");

  a_host_gate: assert property (@(posedge clk) disable iff (rst)
    !panel.normal_position |=> !host_enable && !firmware_run)
    else $error("host served in service position");

  a_tune_flash: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_IDLE && !panel.normal_position && press &&
     panel.test_select == `SEL_TUNE && !spindle_restart)
    |=> tune_go && q.lamps.result == `SEL_TUNE ##1 !tune_go)
    else $error("tuning not started with 2 shown");

  a_descend: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_WAIT && test_rsp.done && !test_rsp.fail && !q.fmt_err &&
     !fmt_early && !q.service && q.cur != `TEST_LAST && !spindle_restart)
    |=> q.st == ST_RUN && q.cur == $past(q.cur) - 4'h1
        ##1 test_req.go && test_req.num == $past(q.cur))
    else $error("suite order broken");

  a_hang_arith: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_WAIT && test_rsp.done && test_rsp.fail && !held &&
     q.cur == `TEST_ARITH && !spindle_restart)
    |=> q.st == ST_HANG && q.lamps.result == `TEST_ARITH)
    else $error("test 16 failure did not hang");

  a_eighth_early: assert property (@(posedge clk) disable iff (rst)
    (q.st == ST_WAIT && (fmt_early || q.fmt_err) && test_rsp.done &&
     !held && !spindle_restart) |=> q.lamps.fail)
    else $error("early eighth-word flag not failed");

  a_read_once: assert property (@(posedge clk) disable iff (rst)
    (bus.rd && bus.addr == `REG_STATUS) |=> rdata == status_word($past(q)))
    else $error("status read data wrong");

endmodule

// [test_engine_model.sv]
// Behavioural test engine that answers the sequencer's test requests
`timescale 1ns/1ps
module test_engine_model
  import selftest_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Request and answer
  input  wire test_req_t req,
  output test_rsp_t      rsp,
  // Fault injection and answer latency from the bench
  input  wire logic      fail_en,
  input  wire logic      early,
  input  wire logic [3:0] fail_num,
  input  wire logic [3:0] fail_sec,
  input  wire logic [3:0] lat
);
  logic       busy;
  logic [3:0] num;
  logic [7:0] cnt;

  always_ff @(posedge clk) begin
    rsp.done <= 1'b0;
    rsp.end_of_word_strobe <= 1'b0;
    // Fail and section lines carry noise outside the done cycle
    rsp.fail <= ~rsp.fail;
    rsp.section <= rsp.section + 4'h5;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      rsp.eighth_word_flag <= 1'b0;
      rsp.fail <= 1'b0;
      rsp.section <= 4'h0;
    end else if (req.go) begin
      busy <= 1'b1;
      num <= req.num;
      cnt <= 8'h00;
      rsp.eighth_word_flag <= early;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      if (num == 4'hA && cnt < 8'h08) rsp.end_of_word_strobe <= 1'b1;
      if (num == 4'hA && cnt == 8'h08) rsp.eighth_word_flag <= 1'b1;
      if (cnt >= 8'(lat) + ((num == 4'hA) ? 8'h09 : 8'h00)) begin
        busy <= 1'b0;
        rsp.done <= 1'b1;
        rsp.fail <= fail_en && (num == fail_num);
        rsp.section <= fail_sec;
      end
    end
  end
endmodule

// [testbench.sv]
// Self-checking bench for the self-test sequencer
`timescale 1ns/1ps
module testbench
  import selftest_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        spin = 1'b0;
  panel_in_t   panel = '{1'b1, 4'h0, 1'b0};
  lamps_t      lamps;
  test_req_t   req;
  test_rsp_t   rsp;
  logic        tune_go, seek_go, host_en, fw_run;
  bus_req_t    bus = '0;
  logic [31:0] rdata, d;
  logic        fail_en = 1'b0, early = 1'b0;
  logic [3:0]  fail_num = 4'h0, fail_sec = 4'h0, lat = 4'h1;
  logic [3:0]  gotq[$], expq[$];
  logic [3:0]  fl[3] = '{4'hC, 4'hE, 4'hD};
  int          bad_count = 0, cmp_count = 0, cyc = 0, quiet = 0;
  int          seeks = 0, tunes = 0, i, k;

  selftest_seq #(.FLASH_CYCLES(4)) dut_u (.clk(clk), .rst(rst),
    .spindle_restart(spin), .panel(panel), .lamps(lamps), .test_req(req),
    .test_rsp(rsp), .tune_go(tune_go), .seek_go(seek_go),
    .host_enable(host_en), .firmware_run(fw_run), .bus(bus), .rdata(rdata));

  test_engine_model eng_u (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .fail_en(fail_en), .early(early), .fail_num(fail_num),
    .fail_sec(fail_sec), .lat(lat));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ****************************
  // Monitor and timeout
  // ****************************
  always @(posedge clk) begin
    cyc++;
    quiet = (req.go === 1'b1) ? 0 : quiet + 1;
    if (req.go === 1'b1) gotq.push_back(req.num);
    if (seek_go === 1'b1) seeks++;
    if (tune_go === 1'b1) tunes++;
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_lamps(logic [3:0] r, logic f);
    cmp("lamps", 32'({r, f}), 32'(lamps));
  endtask

  task automatic chk_seq(string n);
    cmp({n, " count"}, expq.size(), gotq.size());
    for (int j = 0; j < expq.size() && j < gotq.size(); j++)
      cmp(n, 32'(expq[j]), 32'(gotq[j]));
    expq.delete();
    gotq.delete();
  endtask

  task automatic suite(int lo);
    for (int j = 15; j >= lo; j--) expq.push_back(4'(j));
  endtask

  task automatic wait_quiet();
    int n0;
    n0 = gotq.size();
    for (k = 0; k < 200 && gotq.size() == n0; k++) @(posedge clk);
    for (k = 0; k < 3000 && quiet < 60; k++) @(posedge clk);
    #1;
  endtask

  task automatic wait_n(int n);
    for (k = 0; k < 2000 && gotq.size() < n; k++) @(posedge clk);
  endtask

  task automatic press();
    @(posedge clk) panel.start <= 1'b1;
    repeat (3) @(posedge clk);
    panel.start <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk) begin
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= v;
    end
    @(posedge clk) bus.wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin
      bus.rd <= 1'b1;
      bus.addr <= a;
    end
    @(posedge clk) bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    void'($urandom(34674));
    repeat (5) @(posedge clk);
    #1;
    chk_lamps(4'hF, 1'b1);
    cmp("host_en", 0, host_en);
    @(posedge clk) rst <= 1'b0;
    suite(1);
    wait_quiet();
    chk_seq("power_on_order");
    chk_lamps(4'h0, 1'b0);
    cmp("fw_run", 1, fw_run);
    $display("test power_on done");
    rd(8'h04, d);
    cmp("status", 0, {d[12:8], d[3:0]});
    rd(8'h08 | 8'($urandom & 32'hF0), d);
    cmp("unmapped", 0, d);
    lat <= 4'($urandom % 8 + 1);
    wr(8'h00, 32'h0000_0001);
    suite(1);
    wait_quiet();
    chk_seq("host_cmd");
    $display("test host_cmd done");
    for (i = 0; i < 3; i++) begin
      fail_en <= 1'b1;
      fail_num <= fl[i];
      fail_sec <= 4'($urandom);
      panel.test_select <= 4'($urandom);
      press();
      suite(fl[i]);
      wait_quiet();
      chk_seq("normal_fail");
      chk_lamps(fl[i], 1'b1);
      cmp("fw_run", fl[i] == 4'hC, fw_run);
      if (fl[i] != 4'hC) begin
        press();
        repeat (8) @(posedge clk);
        cmp("release", 1, host_en);
      end
    end
    fail_en <= 1'b0;
    early <= 1'b1;
    press();
    suite(10);
    wait_quiet();
    chk_seq("fmt_early");
    chk_lamps(4'hA, 1'b1);
    early <= 1'b0;
    fail_en <= 1'b1;
    fail_num <= 4'hF;
    press();
    suite(15);
    wait_quiet();
    chk_lamps(4'hF, 1'b1);
    press();
    wr(8'h00, 32'h0000_0001);
    wait_quiet();
    chk_seq("lock");
    fail_en <= 1'b0;
    @(posedge clk) spin <= 1'b1;
    @(posedge clk) spin <= 1'b0;
    suite(1);
    wait_quiet();
    chk_seq("spindle");
    $display("test normal_faults done");
    fail_en <= 1'b1;
    fail_num <= 4'hC;
    @(posedge clk) panel.start <= 1'b1;
    wait_n(8);
    gotq = gotq[0:7];
    suite(12);
    suite(12);
    chk_seq("held");
    panel.start <= 1'b0;
    wait_quiet();
    chk_lamps(4'hC, 1'b1);
    gotq.delete();
    $display("test held_normal done");
    panel.normal_position <= 1'b0;
    for (i = 1; i <= 2; i++) begin
      panel.test_select <= 4'(i);
      wr(8'h00, 32'h0000_0001);
      press();
      for (k = 0; k < 100 && lamps.result !== 4'(i); k++) @(posedge clk);
      #1;
      chk_lamps(4'(i), 1'b0);
      wait_quiet();
      cmp("host_en", 0, host_en);
      chk_seq("no_tests");
    end
    cmp("seeks", 1, seeks);
    cmp("tunes", 1, tunes);
    fail_en <= 1'b0;
    fail_num <= 4'h5;
    panel.test_select <= 4'h5;
    press();
    wait_n(3);
    fail_en <= 1'b1;
    wait_quiet();
    chk_lamps(fail_sec, 1'b1);
    for (i = 0; i < gotq.size(); i++) expq.push_back(4'h5);
    chk_seq("loop");
    press();
    expq.push_back(4'h5);
    wait_quiet();
    chk_seq("rerun");
    @(posedge clk) panel.start <= 1'b1;
    wait_n(3);
    gotq = gotq[0:2];
    expq = '{4'h5, 4'h5, 4'h5};
    chk_seq("svc_held");
    panel.start <= 1'b0;
    wait_quiet();
    gotq.delete();
    fail_en <= 1'b0;
    @(posedge clk) spin <= 1'b1;
    @(posedge clk) spin <= 1'b0;
    suite(1);
    wait_quiet();
    chk_seq("svc_spindle");
    fail_en <= 1'b1;
    fail_num <= 4'h7;
    panel.test_select <= 4'h0;
    press();
    suite(7);
    wait_quiet();
    chk_seq("svc_suite");
    chk_lamps(4'h7, 1'b1);
    fail_num <= 4'hF;
    press();
    wait_quiet();
    chk_lamps(4'hF, 1'b1);
    $display("test service done");
    end_of_test();
  end
endmodule
